// File: bench/mhbi_partner.sv
// Far side model: bus arbiter, ready source, buffer memory and port latch
`timescale 1ns/1ps
module mhbi_partner
  import mhbi_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             bus_req,
  input  wire logic             ads_out,
  input  wire logic             owned,
  input  wire logic [3:0]       waits,
  input  wire logic [3:0]       gnt_dly,
  input  wire logic [BUS_W-1:0] mem_data,
  output logic                  bus_grant_ack,
  output logic                  ready,
  output logic      [BUS_W-1:0] drive_val
);
  logic [7:0]       ph_reg;
  logic [3:0]       gc_reg;
  logic [BUS_W-1:0] pat_reg;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_reg  <= 8'h00;
      gc_reg  <= 4'h0;
      pat_reg <= 16'h5A5A;
    end else begin
      pat_reg <= pat_reg + 16'h3A5B;
      gc_reg  <= bus_req ? gc_reg + {3'h0, gc_reg != 4'hF} : 4'h0;
      ph_reg  <= ads_out ? 8'h01 : ph_reg + {7'h0, ph_reg != 8'h00 && ph_reg != 8'hFF};
    end
  end
  // Grant comes only after the arbitration delay and drops with the request
  assign bus_grant_ack = bus_req && gc_reg >= gnt_dly;
  // Wait states requested from t3 on, one clock each
  assign ready = ph_reg >= 8'h02 && ph_reg < 8'h02 + {4'h0, waits};
  // Free lines never hold old data: memory or latch while owned past t1, noise otherwise
  assign drive_val = (owned && !ads_out) ? mem_data : pat_reg;
endmodule

// File: bench/testbench.sv
// Self-checking bench for the host bus interface
`timescale 1ns/1ps
module testbench;
  import mhbi_pkg::*;
  logic              clk, rst, cs_n, ads_in, srd_n, swr_n, dma_valid, host_drv;
  logic [SEL_W-1:0]  sel, reg_addr;
  logic [BYTE_W-1:0] host_val, reg_rdata, reg_wdata;
  logic [3:0]        waits, gnt_dly;
  logic [BUS_W-1:0]  mem_data, bus_in, bus_out, bus_oe, part_val, dma_rdata;
  logic              ads_out, ads_oe, ack_n, bus_req, gnt, ready, mwr_n, mwr_oe, prd_n;
  logic              reg_rd, reg_wr, dma_taken, dma_done;
  mhbi_dma_cmd_t     dma_cmd;
  int                n_errors, n_checks;
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < BUS_W; i++) begin
      bus_in[i] = bus_oe[i] ? bus_out[i]
                : (host_drv && i < BYTE_W) ? host_val[i%BYTE_W] : part_val[i];
    end
  end
  assign reg_rdata = {4'hC, reg_addr};
  mhbi_top dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .register_select(sel),
    .address_latch_strobe_in(ads_in), .address_latch_strobe_out(ads_out),
    .address_latch_strobe_oe(ads_oe), .slave_read_strobe_n(srd_n),
    .slave_write_strobe_n(swr_n), .ack_n(ack_n), .muxed_addr_data_bus_in(bus_in),
    .muxed_addr_data_bus_out(bus_out), .muxed_addr_data_bus_oe(bus_oe),
    .bus_req(bus_req), .bus_grant_ack(gnt), .ready(ready),
    .master_write_strobe_n(mwr_n), .master_write_strobe_oe(mwr_oe),
    .port_read_strobe_n(prd_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .dma_valid(dma_valid), .dma_cmd(dma_cmd), .dma_taken(dma_taken),
    .dma_done(dma_done), .dma_rdata(dma_rdata)
  );
  mhbi_partner partner (
    .clk(clk), .rst(rst), .bus_req(bus_req), .ads_out(ads_out), .owned(mwr_oe),
    .waits(waits), .gnt_dly(gnt_dly), .mem_data(mem_data), .bus_grant_ack(gnt),
    .ready(ready), .drive_val(part_val)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // Latched select is spoiled after the strobe falls; flow-through gets it late
  task automatic reg_access(input bit wr, input logic [SEL_W-1:0] s, input bit flow,
                            input logic [BYTE_W-1:0] d);
    int k;
    @(posedge clk);
    cs_n   <= 1'b0;
    sel    <= flow ? ~s : s;
    ads_in <= 1'b1;
    @(posedge clk);
    ads_in <= flow;
    @(posedge clk);
    sel   <= flow ? s : ~s;
    swr_n <= !wr;
    srd_n <= wr;
    k = 0;
    do begin
      step();
      k++;
    end while (ack_n !== 1'b0 && k < 20);
    check(16'(k), 16'h0002);
    check(reg_addr, s);
    check(reg_rd, !wr);
    check(bus_oe, wr ? BUS_NONE : BUS_LOW);
    if (!wr) check(bus_out[7:0], {4'hC, s});
    @(posedge clk);
    host_drv <= wr;
    host_val <= d;
    @(posedge clk);
    swr_n <= 1'b1;
    srd_n <= 1'b1;
    step();
    if (wr) check(reg_wr, 1'b1);
    if (wr) check(reg_wdata, d);
    k = 0;
    do begin
      step();
      k++;
    end while (ack_n !== 1'b1 && k < 20);
    check(ack_n, 1'b1);
    check(bus_oe, BUS_NONE);
    @(posedge clk);
    cs_n     <= 1'b1;
    host_drv <= 1'b0;
    $display("test register access done");
  endtask
  task automatic cs_idle;
    @(posedge clk);
    sel   <= 4'h5;
    srd_n <= 1'b0;
    repeat (6) begin
      step();
      check(ack_n, 1'b1);
      check(reg_rd, 1'b0);
    end
    @(posedge clk);
    srd_n <= 1'b1;
    $display("test chip select high done");
  endtask
  task automatic dma_run(input mhbi_dma_cmd_t c, input logic [3:0] w, input logic [3:0] g,
                         input logic [BUS_W-1:0] m);
    int k;
    int n;
    int t = 0;
    logic [BUS_W-1:0] eoe;
    @(posedge clk);
    waits     <= w;
    gnt_dly   <= g;
    mem_data  <= m;
    dma_cmd   <= c;
    dma_valid <= 1'b1;
    k = 0;
    do begin
      step();
      k++;
      if (ads_out !== 1'b1) check(bus_oe | {15'h0, mwr_oe}, BUS_NONE);
      t += int'(dma_taken === 1'b1);
    end while (ads_out !== 1'b1 && k < 20);
    check(16'(t), 16'h0001);
    check(bus_oe, BUS_ALL);
    check(bus_out, c.addr);
    check(ads_oe, 1'b1);
    @(posedge clk);
    dma_valid <= 1'b0;
    eoe = (c.write && !c.remote) ? BUS_ALL : (c.word ? BUS_NONE : BUS_HIGH);
    n = 0;
    #1;
    while (dma_done !== 1'b1 && n < 20) begin
      n++;
      check(bus_oe, eoe);
      if (c.write && !c.remote)
        check(bus_out, c.word ? c.wdata : {c.addr[15:8], c.wdata[7:0]});
      if (!c.word) check(bus_out[15:8], c.addr[15:8]);
      check(mwr_n, !(c.write && n <= 2 + w));
      check(prd_n, !(c.write && c.remote && n <= 2 + w));
      step();
    end
    check(16'(n), 16'(3 + w));
    check(mwr_oe, 1'b0);
    if (!c.write) check(dma_rdata, c.word ? m : {c.addr[15:8], m[7:0]});
    $display("test dma cycle done");
  endtask
  // Valid held through t4 chains a second cycle with no idle phase between
  task automatic dma_pair(input mhbi_dma_cmd_t c);
    int k;
    @(posedge clk);
    waits     <= 4'h0;
    gnt_dly   <= 4'h0;
    dma_cmd   <= c;
    dma_valid <= 1'b1;
    k = 0;
    do begin
      step();
      k++;
    end while (dma_done !== 1'b1 && k < 20);
    check(16'(k), 16'h0006);
    check({bus_req, ads_out}, 16'h0003);
    check(bus_out, c.addr);
    @(posedge clk);
    dma_valid <= 1'b0;
    k = 0;
    do begin
      step();
      k++;
    end while (dma_done !== 1'b1 && k < 20);
    check(16'(k), 16'h0003);
    check({bus_req, mwr_oe}, 16'h0000);
    $display("test dma back to back done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run needs a little over a hundred clocks
  initial begin
    #(100 * 3000);
    n_errors++;
    report_and_stop();
  end
  initial begin
    n_errors = 0;
    n_checks = 0;
    {rst, cs_n, ads_in, srd_n, swr_n} = 5'h1F;
    {dma_valid, host_drv, sel, host_val, waits, gnt_dly} = '0;
    mem_data = 16'h0000;
    dma_cmd = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step();
    check({ack_n, mwr_oe, bus_req, prd_n, mwr_n}, 16'h0013);
    check(bus_oe, BUS_NONE);
    reg_access(1'b0, 4'h3, 1'b0, 8'h00);
    reg_access(1'b0, 4'hC, 1'b1, 8'h00);
    reg_access(1'b1, 4'hA, 1'b0, 8'hA5);
    reg_access(1'b1, 4'h0, 1'b1, 8'h5A);
    cs_idle();
    dma_run(mhbi_dma_cmd_t'{1'b1, 1'b1, 1'b0, 16'h1234, 16'hBEEF}, 4'h0, 4'h0, 16'h0000);
    dma_run(mhbi_dma_cmd_t'{1'b1, 1'b0, 1'b0, 16'hA55A, 16'h00C3}, 4'h2, 4'h3, 16'h0000);
    dma_run(mhbi_dma_cmd_t'{1'b0, 1'b1, 1'b0, 16'h0F0F, 16'h0000}, 4'h1, 4'h0, 16'hC3A5);
    dma_run(mhbi_dma_cmd_t'{1'b0, 1'b0, 1'b0, 16'h8001, 16'h0000}, 4'h0, 4'h1, 16'h7E81);
    dma_run(mhbi_dma_cmd_t'{1'b1, 1'b1, 1'b1, 16'h3C3C, 16'h0000}, 4'h1, 4'h0, 16'h0F0F);
    dma_pair(mhbi_dma_cmd_t'{1'b1, 1'b1, 1'b0, 16'h4321, 16'h1DEA});
    report_and_stop();
  end
endmodule

// File: logic/mhbi_addr_latch.sv
// Register select latch, transparent while the strobe is high
`timescale 1ns/1ps
module mhbi_addr_latch
  import mhbi_pkg::*;
#(
  parameter int W = SEL_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         enable,
  input  wire logic         strobe,
  input  wire logic [W-1:0] sel_in,
  output logic      [W-1:0] sel_out
);

  typedef struct packed {
    logic [W-1:0] held;
  } mhbi_latch_state_t;

  mhbi_latch_state_t q;
  mhbi_latch_state_t nxt;
  logic              open_now;

  if (W < 1) begin : g_chk
    $error("mhbi_addr_latch needs a nonzero width");
  end

  assign open_now = enable & strobe;

  // Last value seen while open is kept once the strobe falls
  always_comb begin
    nxt = q;
    if (open_now) begin
      nxt.held = sel_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.held <= '0;
    end else begin
      q <= nxt;
    end
  end

  // Flow-through path costs a mux but keeps no cycle of latency
  assign sel_out = open_now ? sel_in : q.held;

  a_latch_hold : assert property (@(posedge clk) disable iff (rst)
    (enable && $past(enable) && !strobe && !$past(strobe)) |-> sel_out == $past(sel_out))
    else $error("Select changed while latch closed");

endmodule

// File: logic/mhbi_edge.sv
// Edge finder for active-low host strobes
`timescale 1ns/1ps
module mhbi_edge
  import mhbi_pkg::*;
#(
  parameter int               N    = STB_N,
  parameter logic [N-1:0]     IDLE = '1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] sig,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  typedef struct packed {
    logic [N-1:0] prev;
  } mhbi_edge_state_t;

  mhbi_edge_state_t q;
  mhbi_edge_state_t nxt;

  if (N < 1) begin : g_chk
    $error("mhbi_edge needs at least one signal");
  end

  always_comb begin
    nxt      = q;
    nxt.prev = sig;
  end

  // Strobes idle high, so reset to that level to avoid a false rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.prev <= IDLE;
    end else begin
      q <= nxt;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_bit
    assign rise[i] = sig[i] & ~q.prev[i];
    assign fall[i] = ~sig[i] & q.prev[i];
  end

endmodule

// File: logic/mhbi_pkg.sv
// Shared widths, phase codes and carriers of the host bus interface
package mhbi_pkg;

  localparam int BUS_W  = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W  = 4;
  localparam int STB_N  = 2;
  localparam int RD_BIT = 1;
  localparam int WR_BIT = 0;

  localparam logic [BUS_W-1:0]  BUS_ALL  = 16'hFFFF;
  localparam logic [BUS_W-1:0]  BUS_NONE = 16'h0000;
  localparam logic [BUS_W-1:0]  BUS_LOW  = 16'h00FF;
  localparam logic [BUS_W-1:0]  BUS_HIGH = 16'hFF00;
  localparam logic [BYTE_W-1:0] BYTE_NONE = 8'h00;
  localparam logic [SEL_W-1:0]  SEL_NONE  = 4'h0;
  localparam logic [STB_N-1:0]  STB_IDLE  = 2'h3;

  // Gray along idle, request, t1, t2, t3, t4; the wait phase sits beside t3
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_REQ  = 3'h1,
    ST_T1   = 3'h3,
    ST_T2   = 3'h2,
    ST_T3   = 3'h6,
    ST_TW   = 3'h7,
    ST_T4   = 3'h4
  } mhbi_phase_t;

  typedef struct packed {
    logic             write;
    logic             word;
    logic             remote;
    logic [BUS_W-1:0] addr;
    logic [BUS_W-1:0] wdata;
  } mhbi_dma_cmd_t;

  typedef struct packed {
    mhbi_phase_t       ph;
    mhbi_dma_cmd_t     cmd;
    logic              pend;
    logic              is_rd;
    logic              ack_n;
    logic [SEL_W-1:0]  sel;
    logic [BYTE_W-1:0] rbyte;
    logic              rd_pulse;
    logic              wr_pulse;
    logic [BYTE_W-1:0] wbyte;
    logic [BUS_W-1:0]  bus_out;
    logic [BUS_W-1:0]  bus_oe;
    logic              ads_out;
    logic              mwr_n;
    logic              prd_n;
    logic              done;
    logic [BUS_W-1:0]  rdata;
  } mhbi_top_state_t;

  function automatic logic mhbi_owns(mhbi_phase_t p);
    return (p == ST_T1) || (p == ST_T2) || (p == ST_T3) || (p == ST_TW) || (p == ST_T4);
  endfunction

  function automatic logic mhbi_strobe_ph(mhbi_phase_t p);
    return (p == ST_T2) || (p == ST_T3) || (p == ST_TW);
  endfunction

endpackage

// File: logic/mhbi_top.sv
// Host bus interface: register slave port and DMA bus master cycles
`timescale 1ns/1ps
module mhbi_top
  import mhbi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic [SEL_W-1:0]  register_select,
  input  wire logic              address_latch_strobe_in,
  output logic                   address_latch_strobe_out,
  output logic                   address_latch_strobe_oe,
  input  wire logic              slave_read_strobe_n,
  input  wire logic              slave_write_strobe_n,
  output logic                   ack_n,
  input  wire logic [BUS_W-1:0]  muxed_addr_data_bus_in,
  output logic      [BUS_W-1:0]  muxed_addr_data_bus_out,
  output logic      [BUS_W-1:0]  muxed_addr_data_bus_oe,
  output logic                   bus_req,
  input  wire logic              bus_grant_ack,
  input  wire logic              ready,
  output logic                   master_write_strobe_n,
  output logic                   master_write_strobe_oe,
  output logic                   port_read_strobe_n,
  output logic      [SEL_W-1:0]  reg_addr,
  output logic                   reg_rd,
  input  wire logic [BYTE_W-1:0] reg_rdata,
  output logic                   reg_wr,
  output logic      [BYTE_W-1:0] reg_wdata,
  input  wire logic              dma_valid,
  input  wire mhbi_dma_cmd_t     dma_cmd,
  output logic                   dma_taken,
  output logic                   dma_done,
  output logic      [BUS_W-1:0]  dma_rdata
);

  ////////////////////////////////////////////////////////////////
  mhbi_top_state_t   q;
  mhbi_top_state_t   nxt;
  logic              own_q;
  logic              own_next;
  logic              latch_en;
  logic [SEL_W-1:0]  latched_sel;
  logic [STB_N-1:0]  stb;
  logic [STB_N-1:0]  stb_rise;
  logic [STB_N-1:0]  stb_fall;
  logic              drive_data;

  assign own_q = mhbi_owns(q.ph);
  assign stb   = {slave_read_strobe_n, slave_write_strobe_n};

  // Latch only listens as an input and only in slave mode
  assign latch_en = ~cs_n & ~own_q;

  mhbi_addr_latch #(
    .W (SEL_W)
  ) u_latch (
    .clk     (clk),
    .rst     (rst),
    .enable  (latch_en),
    .strobe  (address_latch_strobe_in),
    .sel_in  (register_select),
    .sel_out (latched_sel)
  );

  mhbi_edge #(
    .N    (STB_N),
    .IDLE (STB_IDLE)
  ) u_edge (
    .clk  (clk),
    .rst  (rst),
    .sig  (stb),
    .rise (stb_rise),
    .fall (stb_fall)
  );

  ////////////////////////////////////////////////////////////////
  always_comb begin
    nxt          = q;
    nxt.rd_pulse = 1'b0;
    nxt.wr_pulse = 1'b0;
    nxt.done     = 1'b0;
    dma_taken    = 1'b0;
    drive_data   = 1'b0;

    // DMA memory cycle sequencer
    case (q.ph)
      ST_IDLE: begin
        if (dma_valid) begin
          nxt.ph = ST_REQ;
        end
      end
      ST_REQ: begin
        if (bus_grant_ack) begin
          nxt.ph    = ST_T1;
          nxt.cmd   = dma_cmd;
          dma_taken = 1'b1;
        end
      end
      ST_T1: begin
        nxt.ph = ST_T2;
      end
      ST_T2: begin
        nxt.ph = ST_T3;
      end
      ST_T3: begin
        nxt.ph = ready ? ST_TW : ST_T4;
      end
      ST_TW: begin
        nxt.ph = ready ? ST_TW : ST_T4;
      end
      ST_T4: begin
        nxt.done = 1'b1;
        if (!q.cmd.write) begin
          nxt.rdata = muxed_addr_data_bus_in;
        end
        // Back to back cycles keep the bus while the grant holds
        if (dma_valid && bus_grant_ack) begin
          nxt.ph    = ST_T1;
          nxt.cmd   = dma_cmd;
          dma_taken = 1'b1;
        end else begin
          nxt.ph = ST_IDLE;
        end
      end
      default: begin
        nxt.ph = ST_IDLE;
      end
    endcase

    own_next = mhbi_owns(nxt.ph);

    // Slave access tracking; chip select high clears the pending flag and so the acknowledge
    if (cs_n) begin
      nxt.pend = 1'b0;
    end else if (q.pend) begin
      nxt.pend = ~(slave_read_strobe_n & slave_write_strobe_n);
    end else if (|stb_fall) begin
      nxt.pend  = 1'b1;
      nxt.is_rd = stb_fall[RD_BIT];
      nxt.sel   = latched_sel;
    end

    // One clock of synchronisation, and no grant while mastering
    nxt.ack_n = ~(q.pend & nxt.pend & ~own_next);

    if (q.ack_n && !nxt.ack_n) begin
      nxt.rbyte    = reg_rdata;
      nxt.rd_pulse = q.is_rd;
    end

    if (!q.ack_n && !q.is_rd && stb_rise[WR_BIT]) begin
      nxt.wr_pulse = 1'b1;
      nxt.wbyte    = muxed_addr_data_bus_in[BYTE_W-1:0];
    end

    // Pin values for the coming phase, all taken from flip-flops
    nxt.bus_out = BUS_NONE;
    nxt.bus_oe  = BUS_NONE;
    nxt.ads_out = 1'b0;
    nxt.mwr_n   = 1'b1;
    nxt.prd_n   = 1'b1;
    // Remote writes leave the data lines to the external latch
    drive_data  = nxt.cmd.write & ~nxt.cmd.remote;
    case (nxt.ph)
      ST_T1: begin
        nxt.bus_out = nxt.cmd.addr;
        nxt.bus_oe  = BUS_ALL;
        nxt.ads_out = 1'b1;
      end
      ST_T2, ST_T3, ST_TW, ST_T4: begin
        if (nxt.cmd.word) begin
          nxt.bus_out = nxt.cmd.wdata;
          nxt.bus_oe  = drive_data ? BUS_ALL : BUS_NONE;
        end else begin
          nxt.bus_out = {nxt.cmd.addr[BUS_W-1:BYTE_W], nxt.cmd.wdata[BYTE_W-1:0]};
          nxt.bus_oe  = drive_data ? BUS_ALL : BUS_HIGH;
        end
        // Data stays through t4 so it is valid when the strobe rises
        nxt.mwr_n = ~(nxt.cmd.write & mhbi_strobe_ph(nxt.ph));
        nxt.prd_n = ~(nxt.cmd.write & nxt.cmd.remote & mhbi_strobe_ph(nxt.ph));
      end
      default: begin
        if (!nxt.ack_n && nxt.is_rd) begin
          nxt.bus_out = {BYTE_NONE, nxt.rbyte};
          nxt.bus_oe  = BUS_LOW;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.ph       <= ST_IDLE;
      q.cmd      <= '0;
      q.pend     <= 1'b0;
      q.is_rd    <= 1'b0;
      q.ack_n    <= 1'b1;
      q.sel      <= SEL_NONE;
      q.rbyte    <= BYTE_NONE;
      q.rd_pulse <= 1'b0;
      q.wr_pulse <= 1'b0;
      q.wbyte    <= BYTE_NONE;
      q.bus_out  <= BUS_NONE;
      q.bus_oe   <= BUS_NONE;
      q.ads_out  <= 1'b0;
      q.mwr_n    <= 1'b1;
      q.prd_n    <= 1'b1;
      q.done     <= 1'b0;
      q.rdata    <= BUS_NONE;
    end else begin
      q <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign muxed_addr_data_bus_out  = q.bus_out;
  assign muxed_addr_data_bus_oe   = q.bus_oe;
  assign address_latch_strobe_out = q.ads_out;
  // Address and master write strobes float whenever the bus is not ours; the port read strobe is always driven
  assign address_latch_strobe_oe  = own_q;
  assign master_write_strobe_oe   = own_q;
  assign master_write_strobe_n    = q.mwr_n;
  assign port_read_strobe_n       = q.prd_n;
  assign bus_req                  = (q.ph != ST_IDLE);
  assign ack_n                    = q.ack_n;
  assign reg_addr                 = q.sel;
  assign reg_rd                   = q.rd_pulse;
  assign reg_wr                   = q.wr_pulse;
  assign reg_wdata                = q.wbyte;
  assign dma_done                 = q.done;
  assign dma_rdata                = q.rdata;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_granted;
    q.ph == ST_REQ && bus_grant_ack;
  endsequence

  sequence s_front;
    q.ph == ST_T1 ##1 q.ph == ST_T2 ##1 q.ph == ST_T3;
  endsequence

  a_cycle_order : assert property (s_granted |=> s_front)
    else $error("DMA cycle phases out of order");

  a_ready_wait : assert property ((q.ph inside {ST_T3, ST_TW}) && ready
    |=> q.ph == ST_TW)
    else $error("Ready high did not add a wait phase");

  a_ready_end : assert property ((q.ph inside {ST_T3, ST_TW}) && !ready
    |=> q.ph == ST_T4)
    else $error("Ready low did not end the wait");

  a_addr_phase : assert property (q.ph == ST_T1 |->
    muxed_addr_data_bus_oe == BUS_ALL && muxed_addr_data_bus_out == q.cmd.addr
    && address_latch_strobe_out && address_latch_strobe_oe)
    else $error("Address not driven in t1");

  a_word_data : assert property ((q.ph inside {ST_T2, ST_T3, ST_TW, ST_T4}) && q.cmd.word
    && q.cmd.write && !q.cmd.remote |->
    muxed_addr_data_bus_oe == BUS_ALL && muxed_addr_data_bus_out == q.cmd.wdata)
    else $error("Word data not on all lines");

  a_byte_addr : assert property ((q.ph inside {ST_T2, ST_T3, ST_TW, ST_T4}) && !q.cmd.word
    |-> (muxed_addr_data_bus_oe & BUS_HIGH) == BUS_HIGH
    && muxed_addr_data_bus_out[BUS_W-1:BYTE_W] == q.cmd.addr[BUS_W-1:BYTE_W])
    else $error("Byte mode lost upper address");

  a_write_strobe : assert property (own_q |->
    (master_write_strobe_n == !(q.cmd.write && mhbi_strobe_ph(q.ph))))
    else $error("Write strobe in wrong phase");

  a_port_read : assert property (own_q && q.cmd.remote && q.cmd.write |->
    (port_read_strobe_n == !mhbi_strobe_ph(q.ph)))
    else $error("Port read strobe wrong in remote write");

  a_float_idle : assert property (!own_q |-> !master_write_strobe_oe
    && !address_latch_strobe_oe && (muxed_addr_data_bus_oe & BUS_HIGH) == BUS_NONE)
    else $error("Master output driven without grant");

  a_upper_float : assert property (!ack_n |-> muxed_addr_data_bus_oe[BUS_W-1:BYTE_W] == '0
    && (!q.is_rd || muxed_addr_data_bus_out[BYTE_W-1:0] == q.rbyte))
    else $error("Register access drove upper lines");

  a_cs_ignore : assert property (cs_n |=> ack_n && !reg_rd)
    else $error("Access taken with chip select high");

  a_ack_sync : assert property ($fell(ack_n) |-> $past(q.pend) && !own_q)
    else $error("Acknowledge before synchronisation");

  a_write_take : assert property (!ack_n && !q.is_rd && stb_rise[WR_BIT] |=>
    reg_wr && reg_wdata == $past(muxed_addr_data_bus_in[BYTE_W-1:0]))
    else $error("Write data not taken on strobe rise");

endmodule
